// ==== timer_pkg.sv ====
package timer_pkg;

   // port instruction selects
   localparam logic [5:0]  SEL_FC_LOW     = 6'h0A;
   localparam logic [5:0]  SEL_FC_HIGH    = 6'h0B;
   localparam logic [5:0]  SEL_TIME_BASE  = 6'h19;
   localparam logic [5:0]  SEL_TMR_A_CMD  = 6'h1C;
   localparam logic [5:0]  SEL_TMR_B_CMD  = 6'h1D;
   localparam logic [5:0]  SEL_FC_CMD     = 6'h1F;
   localparam logic [5:0]  SEL_TA_LOW     = 6'h30;
   localparam logic [5:0]  SEL_TB_LOW     = 6'h34;

   // command field positions
   localparam int          MODE_HI        = 3;
   localparam int          MODE_LO        = 2;
   localparam int          RATE_HI        = 1;
   localparam int          RATE_LO        = 0;

   // mode encodings
   localparam logic [1:0]  TMR_STOP       = 2'h0;
   localparam logic [1:0]  TMR_EVENT      = 2'h1;
   localparam logic [1:0]  TMR_TIMING     = 2'h2;
   localparam logic [1:0]  TMR_PULSE      = 2'h3;
   localparam logic [1:0]  FC_HALT        = 2'h0;
   localparam logic [1:0]  FC_RELOAD      = 2'h1;
   localparam logic [1:0]  FC_TONE        = 2'h2;
   localparam logic [1:0]  FC_PULSE       = 2'h3;

   // divider exponents
   localparam int          TA_EXP0 = 3;
   localparam int          TA_EXP1 = 7;
   localparam int          TA_EXP2 = 11;
   localparam int          TA_EXP3 = 15;
   localparam int          TB_EXP1 = 5;
   localparam int          TB_EXP2 = 9;
   localparam int          TB_EXP3 = 13;
   localparam int          BASE_EXP4 = 3;
   localparam int          BASE_EXP5 = 4;
   localparam int          BASE_EXP6 = 5;
   localparam int          BASE_EXP7 = 14;
   localparam int          BASE_EXPC = 1;
   localparam int          BASE_EXPD = 6;
   localparam int          BASE_EXPE = 8;
   localparam int          BASE_EXPF = 10;
   localparam int          FC_EXP0  = 0;
   localparam int          FC_EXP1  = 2;
   localparam int          FC_EXP2  = 4;
   localparam int          FC_EXP3  = 6;

   // reset values
   localparam logic [3:0]  CMD_RESET      = 4'h0;
   localparam logic [11:0] TMR_RESET      = 12'h000;
   localparam logic [7:0]  FC_RESET       = 8'h00;

   // one-cycle tick when bit k-1 of a free counter rises; k = 0 ticks every step
   function automatic logic div_tick(input logic [15:0] cnt, input int k);
      logic [15:0] half;
      logic [15:0] mask;
      half = 16'h0001;
      mask = 16'h0000;
      if (k == 0)
      begin
         return 1'b1;
      end
      half = 16'h0001 << (k - 1);
      mask = 16'((half << 1) - 16'h0001);
      return ((16'(cnt + 16'h0001)) & mask) == half;
   endfunction : div_tick

endpackage : timer_pkg

// ==== dual_timer_and_fast_counter.sv ====
// Summary of operation
// - general timer modes: stop, event, timing, pulse
// - each timer has its own command port
// - first timer rate: slow/2^3,2^7,2^11,2^15
// - second timer rate: fast counter, slow/2^5,2^9,2^13
// - general timer overflow raises its irq
// - event mode counts external pin rising edges
// - timing mode counts selected internal pulse edges
// - pulse mode counts pulses while pin qualifies
// - timers independent; nibble preset and readback
// - time base: eight rates, 00xx off, 10xx reserved
// - time base divider table, slow mode subset
// - fast counter: 8-bit up, both system modes
// - fast counter modes: halt, reload, tone, pulse
// - fast counter clock: slow/1,/4, fast/16,/64
// - fast overflow irq except halted or tone
// - preset loaded at start and each overflow
// - fast preset and count split over nibbles
// - tone toggles once per overflow
// - outside tone: shared pin high, dedicated low
// - gate pin is input in pulse mode while gate latch is high
module dual_timer_and_fast_counter
   import timer_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // port instruction access
   input  wire logic       port_wr,
   input  wire logic       port_rd,
   input  wire logic [5:0] port_sel,
   input  wire logic [3:0] port_wdata,
   output logic      [3:0] port_rdata,
   // clock source and system mode
   input  wire logic       slow_oscillator,
   input  wire logic       slow_mode,
   // external pins
   input  wire logic       first_timer_event_pin,
   input  wire logic       second_timer_event_pin,
   input  wire logic       fast_counter_gate_pin,
   input  wire logic       gate_latch_high,
   output logic            gate_pin_is_input,
   // interrupt requests
   output logic            time_base_irq,
   output logic            first_timer_overflow_irq,
   output logic            second_timer_overflow_irq,
   output logic            fast_counter_overflow_irq,
   // tone pins
   output logic            tone_out_shared_pin,
   output logic            tone_out_dedicated_pin
);

   logic [3:0]  time_base_control_r;
   logic [3:0]  timer_a_command_r;
   logic [3:0]  timer_b_command_r;
   logic [3:0]  fast_counter_command_r;
   logic [7:0]  fast_counter_preset_r;
   logic [7:0]  fast_counter_r;
   logic [11:0] tmr_r [2];
   logic [1:0]  ev_q_r;
   logic        slow_q_r;
   logic [15:0] slow_div_r;
   logic [15:0] fast_div_r;
   logic [3:0]  port_rdata_r;
   logic        tbase_r;
   logic [1:0]  tmr_irq_r;
   logic        fc_irq_r;
   logic        tone_r;

   logic        slow_edge;
   logic        tb_tick;
   logic [1:0]  ev_in;
   logic [1:0]  ev_rise;
   logic [1:0]  rate_pulse;
   logic [1:0]  tmr_inc;
   logic [1:0]  tmr_wrote;
   logic [1:0]  first_timer_mode_sel;
   logic [1:0]  second_timer_mode_sel;
   logic [1:0]  first_timer_rate_sel;
   logic [1:0]  second_timer_rate_sel;
   logic [1:0]  fast_counter_mode_sel;
   logic [1:0]  fast_counter_clock_sel;
   logic        fc_src;
   logic        fc_inc;
   logic        fc_ovf;
   logic        fc_start;

   function automatic logic [5:0] tmr_sel(input int i, input int n);
      logic [5:0] base;
      base = (i == 0) ? SEL_TA_LOW : SEL_TB_LOW;
      return 6'(base + 6'(n));
   endfunction : tmr_sel

   function automatic logic slow_tick(input logic edge_in, input logic [15:0] cnt,
                                      input int k);
      return edge_in & div_tick(cnt, k);
   endfunction : slow_tick

   assign first_timer_mode_sel   = timer_a_command_r[MODE_HI:MODE_LO];
   assign first_timer_rate_sel   = timer_a_command_r[RATE_HI:RATE_LO];
   assign second_timer_mode_sel  = timer_b_command_r[MODE_HI:MODE_LO];
   assign second_timer_rate_sel  = timer_b_command_r[RATE_HI:RATE_LO];
   assign fast_counter_mode_sel  = fast_counter_command_r[MODE_HI:MODE_LO];
   assign fast_counter_clock_sel = fast_counter_command_r[RATE_HI:RATE_LO];

   assign slow_edge = slow_oscillator & ~slow_q_r;
   assign ev_in     = {second_timer_event_pin, first_timer_event_pin};
   assign ev_rise   = ev_in & ~ev_q_r;

   // prescalers
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         slow_q_r   <= 1'b0;
         slow_div_r <= 16'h0000;
         fast_div_r <= 16'h0000;
         ev_q_r     <= 2'h0;
      end
      else
      begin
         slow_q_r   <= slow_oscillator;
         ev_q_r     <= ev_in;
         fast_div_r <= 16'(fast_div_r + 16'h0001);
         if (slow_edge)
         begin
            slow_div_r <= 16'(slow_div_r + 16'h0001);
         end
      end
   end

   // command and preset ports
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         time_base_control_r    <= CMD_RESET;
         timer_a_command_r      <= CMD_RESET;
         timer_b_command_r      <= CMD_RESET;
         fast_counter_command_r <= CMD_RESET;
         fast_counter_preset_r  <= FC_RESET;
      end
      else if (port_wr)
      begin
         unique case (port_sel)
            SEL_TIME_BASE: time_base_control_r <= port_wdata;
            SEL_TMR_A_CMD: timer_a_command_r <= port_wdata;
            SEL_TMR_B_CMD: timer_b_command_r <= port_wdata;
            SEL_FC_CMD:    fast_counter_command_r <= port_wdata;
            SEL_FC_LOW:    fast_counter_preset_r[3:0] <= port_wdata;
            SEL_FC_HIGH:   fast_counter_preset_r[7:4] <= port_wdata;
            default:       ;
         endcase
      end
   end

   // time base rate
   always_comb
   begin
      unique case (time_base_control_r)
         4'h4:    tb_tick = ~slow_mode & slow_tick(slow_edge, slow_div_r, BASE_EXP4);
         4'h5:    tb_tick = ~slow_mode & slow_tick(slow_edge, slow_div_r, BASE_EXP5);
         4'h6:    tb_tick = ~slow_mode & slow_tick(slow_edge, slow_div_r, BASE_EXP6);
         4'h7:    tb_tick = slow_tick(slow_edge, slow_div_r, BASE_EXP7);
         4'hC:    tb_tick = ~slow_mode & slow_tick(slow_edge, slow_div_r, BASE_EXPC);
         4'hD:    tb_tick = slow_tick(slow_edge, slow_div_r, BASE_EXPD);
         4'hE:    tb_tick = slow_tick(slow_edge, slow_div_r, BASE_EXPE);
         4'hF:    tb_tick = slow_tick(slow_edge, slow_div_r, BASE_EXPF);
         default: tb_tick = 1'b0;
      endcase
   end

   // internal pulse for each general timer
   always_comb
   begin
      unique case (first_timer_rate_sel)
         2'h0:    rate_pulse[0] = ~slow_mode & slow_tick(slow_edge, slow_div_r, TA_EXP0);
         2'h1:    rate_pulse[0] = slow_tick(slow_edge, slow_div_r, TA_EXP1);
         2'h2:    rate_pulse[0] = slow_tick(slow_edge, slow_div_r, TA_EXP2);
         default: rate_pulse[0] = slow_tick(slow_edge, slow_div_r, TA_EXP3);
      endcase
      unique case (second_timer_rate_sel)
         2'h0:    rate_pulse[1] = fc_ovf;
         2'h1:    rate_pulse[1] = slow_tick(slow_edge, slow_div_r, TB_EXP1);
         2'h2:    rate_pulse[1] = slow_tick(slow_edge, slow_div_r, TB_EXP2);
         default: rate_pulse[1] = slow_tick(slow_edge, slow_div_r, TB_EXP3);
      endcase
   end

   // count enables, each timer on its own mode
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         tmr_wrote[i] = 1'b0;
         for (int n = 0; n < 3; n++)
            if (port_wr && port_sel == tmr_sel(i, n))
               tmr_wrote[i] = 1'b1;
         unique case ((i == 0) ? first_timer_mode_sel : second_timer_mode_sel)
            TMR_EVENT:  tmr_inc[i] = ev_rise[i];
            TMR_TIMING: tmr_inc[i] = rate_pulse[i];
            TMR_PULSE:  tmr_inc[i] = rate_pulse[i] & ev_in[i];
            default:    tmr_inc[i] = 1'b0;
         endcase
      end
   end

   // general timers: nibble preset wins over a same-cycle count
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         tmr_r[0]  <= TMR_RESET;
         tmr_r[1]  <= TMR_RESET;
         tmr_irq_r <= 2'h0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            tmr_irq_r[i] <= tmr_inc[i] & ~tmr_wrote[i] & (&tmr_r[i]);
            if (tmr_wrote[i])
            begin
               for (int n = 0; n < 3; n++)
                  if (port_sel == tmr_sel(i, n))
                     tmr_r[i][n*4 +: 4] <= port_wdata;
            end
            else if (tmr_inc[i])
               tmr_r[i] <= 12'(tmr_r[i] + 12'h001);
         end
      end
   end

   // fast counter clock and gating
   always_comb
   begin
      unique case (fast_counter_clock_sel)
         2'h0:    fc_src = slow_tick(slow_edge, slow_div_r, FC_EXP0);
         2'h1:    fc_src = slow_tick(slow_edge, slow_div_r, FC_EXP1);
         2'h2:    fc_src = ~slow_mode & div_tick(fast_div_r, FC_EXP2);
         default: fc_src = ~slow_mode & div_tick(fast_div_r, FC_EXP3);
      endcase
   end

   assign gate_pin_is_input = (fast_counter_mode_sel == FC_PULSE) & gate_latch_high;
   assign fc_inc   = (fast_counter_mode_sel != FC_HALT) & fc_src &
                     ((fast_counter_mode_sel != FC_PULSE) |
                      (gate_pin_is_input & fast_counter_gate_pin));
   assign fc_ovf   = fc_inc & (&fast_counter_r);
   assign fc_start = port_wr & (port_sel == SEL_FC_CMD) &
                     (fast_counter_mode_sel == FC_HALT) &
                     (port_wdata[MODE_HI:MODE_LO] != FC_HALT);

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         fast_counter_r <= FC_RESET;
      end
      else if (fc_start || fc_ovf)
      begin
         fast_counter_r <= fast_counter_preset_r;
      end
      else if (fc_inc)
      begin
         fast_counter_r <= 8'(fast_counter_r + 8'h01);
      end
   end

   // fast counter interrupt and tone
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         fc_irq_r <= 1'b0;
         tone_r   <= 1'b0;
      end
      else
      begin
         fc_irq_r <= fc_ovf & ((fast_counter_mode_sel == FC_RELOAD) |
                               (fast_counter_mode_sel == FC_PULSE));
         if (fast_counter_mode_sel != FC_TONE)
         begin
            tone_r <= 1'b0;
         end
         else if (fc_ovf)
         begin
            tone_r <= ~tone_r;
         end
      end
   end

   // time base irq and port reads
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         tbase_r      <= 1'b0;
         port_rdata_r <= 4'h0;
      end
      else
      begin
         tbase_r <= tb_tick;
         if (port_rd)
         begin
            unique case (port_sel)
               SEL_FC_LOW:  port_rdata_r <= fast_counter_r[3:0];
               SEL_FC_HIGH: port_rdata_r <= fast_counter_r[7:4];
               default:     port_rdata_r <= 4'h0;
            endcase
            for (int i = 0; i < 2; i++)
               for (int n = 0; n < 3; n++)
                  if (port_sel == tmr_sel(i, n))
                     port_rdata_r <= tmr_r[i][n*4 +: 4];
         end
      end
   end

   assign port_rdata                = port_rdata_r;
   assign time_base_irq             = tbase_r;
   assign first_timer_overflow_irq  = tmr_irq_r[0];
   assign second_timer_overflow_irq = tmr_irq_r[1];
   assign fast_counter_overflow_irq = fc_irq_r;
   assign tone_out_dedicated_pin    = tone_r;
   assign tone_out_shared_pin       = ~tone_r;

endmodule : dual_timer_and_fast_counter

// ==== dual_timer_sva.sv ====
module dual_timer_checker
   import timer_pkg::*;
(
   // clock and reset
   input wire logic       mclk,
   input wire logic       resetn,
   // register port
   input wire logic       port_wr,
   input wire logic       port_rd,
   input wire logic [5:0] port_sel,
   input wire logic [3:0] port_wdata,
   input wire logic [3:0] port_rdata,
   // pins and requests
   input wire logic       gate_latch_high,
   input wire logic       gate_pin_is_input,
   input wire logic       time_base_irq,
   input wire logic       first_timer_overflow_irq,
   input wire logic       second_timer_overflow_irq,
   input wire logic       fast_counter_overflow_irq,
   input wire logic       tone_out_shared_pin,
   input wire logic       tone_out_dedicated_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] fc_mode_r;
   logic [3:0] tb_ctl_r;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   // shadows of the write-only command ports
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         fc_mode_r <= FC_HALT;
      else if (port_wr && port_sel == SEL_FC_CMD)
         fc_mode_r <= port_wdata[MODE_HI:MODE_LO];
   end
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         tb_ctl_r <= CMD_RESET;
      else if (port_wr && port_sel == SEL_TIME_BASE)
         tb_ctl_r <= port_wdata;
   end

   sequence s_one_cycle(sig);
      sig ##1 !sig;
   endsequence

   a_ta_irq_pulse:
      assert property ($rose(first_timer_overflow_irq) |-> s_one_cycle(first_timer_overflow_irq))
      else $error("timer a request not one cycle");
   a_tb_irq_pulse:
      assert property ($rose(second_timer_overflow_irq) |-> s_one_cycle(second_timer_overflow_irq))
      else $error("timer b request not one cycle");
   a_tbase_pulse:
      assert property ($rose(time_base_irq) |-> s_one_cycle(time_base_irq))
      else $error("time base request not one cycle");
   a_tbase_when_off:
      assert property (time_base_irq |-> $past(tb_ctl_r[2]) || $past(tb_ctl_r[2], 2))
      else $error("time base request while disabled");
   a_fc_irq_mode:
      assert property (fast_counter_overflow_irq |-> $past(fc_mode_r[0]) || $past(fc_mode_r[0], 2))
      else $error("fast request while halted or in tone");
   a_tone_idle_lvl:
      assert property (fc_mode_r != FC_TONE && $past(fc_mode_r) != FC_TONE
                       |-> tone_out_shared_pin && !tone_out_dedicated_pin)
      else $error("tone pins not idle");
   a_tone_rise_mode:
      assert property ($rose(tone_out_dedicated_pin) |-> $past(fc_mode_r) == FC_TONE)
      else $error("tone pin rose outside tone mode");
   a_gate_input:
      assert property (gate_pin_is_input == (fc_mode_r == FC_PULSE && gate_latch_high))
      else $error("gate direction wrong");
   a_rdata_hold:
      assert property (!port_rd |=> $stable(port_rdata))
      else $error("read data moved without read");
endmodule : dual_timer_checker

// ==== cpu_port_model.sv ====
module cpu_port_model
   import timer_pkg::*;
(
   // clock
   input  wire logic       mclk,
   // port instruction bus
   output logic            port_wr,
   output logic            port_rd,
   output logic      [5:0] port_sel,
   output logic      [3:0] port_wdata,
   input  wire logic [3:0] port_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      port_wr = 1'b0;
      port_rd = 1'b0;
      port_sel = 6'h00;
      port_wdata = 4'h0;
   end

   task automatic wr(input logic [5:0] s, input logic [3:0] d);
      @(posedge mclk);
      port_wr    <= 1'b1;
      port_sel   <= s;
      port_wdata <= d;
      @(posedge mclk);
      port_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] s, output logic [3:0] d);
      @(posedge mclk);
      port_rd  <= 1'b1;
      port_sel <= s;
      @(posedge mclk);
      port_rd <= 1'b0;
      @(posedge mclk);
      #1;
      d = port_rdata;
   endtask : rd

   // low, mid, high nibbles
   task automatic preset(input logic [5:0] base, input logic [11:0] v);
      wr(base, v[3:0]);
      wr(base + 6'h01, v[7:4]);
      wr(base + 6'h02, v[11:8]);
   endtask : preset
endmodule : cpu_port_model

// ==== tb.sv ====
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import timer_pkg::*;

   logic       mclk = 1'b0;
   logic       resetn = 1'b0;
   logic       port_wr, port_rd, osc = 1'b0, slow = 1'b0;
   logic       ev_a = 1'b0, ev_b = 1'b0, gate = 1'b0, glatch = 1'b0;
   logic [5:0] port_sel;
   logic [3:0] port_wdata, port_rdata;
   logic       gate_in, tbase, irq_a, irq_b, irq_fc, tone_sh, tone_dd, prev;
   int         failures = 0, checks = 0, cyc = 0, n_irq[4] = '{0, 0, 0, 0};

   dual_timer_and_fast_counter u_dut (.mclk(mclk), .resetn(resetn), .port_wr(port_wr),
      .port_rd(port_rd), .port_sel(port_sel), .port_wdata(port_wdata), .port_rdata(port_rdata),
      .slow_oscillator(osc), .slow_mode(slow), .first_timer_event_pin(ev_a),
      .second_timer_event_pin(ev_b), .fast_counter_gate_pin(gate), .gate_latch_high(glatch),
      .gate_pin_is_input(gate_in), .time_base_irq(tbase), .first_timer_overflow_irq(irq_a),
      .second_timer_overflow_irq(irq_b), .fast_counter_overflow_irq(irq_fc),
      .tone_out_shared_pin(tone_sh), .tone_out_dedicated_pin(tone_dd));
   cpu_port_model u_cpu (.mclk(mclk), .port_wr(port_wr), .port_rd(port_rd),
      .port_sel(port_sel), .port_wdata(port_wdata), .port_rdata(port_rdata));

   initial
   begin
      forever #4 mclk = ~mclk;
   end

   // slow step every 8 clocks; request counters; hang guard
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc % 4 == 3)
         osc <= ~osc;
      n_irq[0] <= n_irq[0] + int'(irq_a === 1'b1);
      n_irq[1] <= n_irq[1] + int'(irq_b === 1'b1);
      n_irq[2] <= n_irq[2] + int'(irq_fc === 1'b1);
      n_irq[3] <= n_irq[3] + int'(tbase === 1'b1);
      if (cyc == 10000)
      begin
         failures++;
         finish_test();
      end
   end

   task automatic chk_rd(input string n, input logic [5:0] s, input logic [3:0] e);
      logic [3:0] d;
      u_cpu.rd(s, d);
      checks++;
      if (d !== e)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, d);
      end
   endtask : chk_rd

   task automatic chk_pin(input string n, input logic e, input logic g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %s expected %b seen %b", n, e, g);
      end
   endtask : chk_pin

   // waits up to lim clocks; stops early once an expected request shows
   task automatic expect_irq(input string n, input int i, input int lim, input bit e);
      int s;
      s = n_irq[i];
      for (int k = 0; k < lim && !(e && n_irq[i] != s); k++)
      begin
         @(posedge mclk);
         #1;
      end
      checks++;
      if ((n_irq[i] != s) != e)
      begin
         failures++;
         $display("[ERR] %s expected %0d seen %0d", n, e, n_irq[i] - s);
      end
   endtask : expect_irq

   task automatic finish_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   initial
   begin
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      chk_pin("tone_sh", 1'b1, tone_sh);
      chk_pin("tone_dd", 1'b0, tone_dd);
      chk_rd("fc_low", SEL_FC_LOW, 4'h0);
      chk_rd("unmapped", 6'h3F, 4'h0);
      $display("test reset done");
      u_cpu.preset(SEL_TA_LOW, 12'hFFE);
      u_cpu.wr(SEL_TMR_A_CMD, 4'h8);
      expect_irq("ta_timing", 0, 300, 1'b1);
      u_cpu.wr(SEL_TMR_A_CMD, 4'h0);
      chk_rd("ta_low", SEL_TA_LOW, 4'h0);
      chk_rd("ta_high", SEL_TA_LOW + 6'h02, 4'h0);
      $display("test timer_a_timing done");
      u_cpu.preset(SEL_TB_LOW, 12'hFFF);
      u_cpu.wr(SEL_TMR_B_CMD, 4'h4);
      expect_irq("tb_quiet", 1, 20, 1'b0);
      @(posedge mclk) ev_b <= 1'b1;
      expect_irq("tb_event", 1, 10, 1'b1);
      chk_rd("ta_hold", SEL_TA_LOW, 4'h0);
      u_cpu.wr(SEL_TMR_B_CMD, 4'h0);
      $display("test timer_b_event done");
      u_cpu.preset(SEL_TA_LOW, 12'hFFF);
      u_cpu.wr(SEL_TMR_A_CMD, 4'hC);
      expect_irq("ta_gated", 0, 200, 1'b0);
      @(posedge mclk) ev_a <= 1'b1;
      expect_irq("ta_pulse", 0, 200, 1'b1);
      u_cpu.wr(SEL_TMR_A_CMD, 4'h0);
      $display("test timer_a_pulse done");
      u_cpu.wr(SEL_FC_HIGH, 4'hF);
      u_cpu.wr(SEL_FC_LOW, 4'hE);
      u_cpu.preset(SEL_TB_LOW, 12'hFFF);
      u_cpu.wr(SEL_TMR_B_CMD, 4'h8);
      u_cpu.wr(SEL_FC_CMD, 4'h4);
      expect_irq("tb_from_fc", 1, 60, 1'b1);
      expect_irq("fc_reload", 2, 60, 1'b1);
      u_cpu.wr(SEL_FC_CMD, 4'h0);
      chk_rd("fc_low", SEL_FC_LOW, 4'hE);
      chk_rd("fc_high", SEL_FC_HIGH, 4'hF);
      u_cpu.wr(SEL_TMR_B_CMD, 4'h0);
      $display("test fast_reload done");
      u_cpu.wr(SEL_FC_CMD, 4'h8);
      prev = tone_dd;
      repeat (20) @(posedge mclk);
      #1;
      chk_pin("tone_toggle", ~prev, tone_dd);
      chk_pin("tone_pair", ~tone_dd, tone_sh);
      expect_irq("fc_tone", 2, 60, 1'b0);
      u_cpu.wr(SEL_FC_CMD, 4'h0);
      repeat (2) @(posedge mclk);
      chk_pin("tone_sh_idle", 1'b1, tone_sh);
      chk_pin("tone_dd_idle", 1'b0, tone_dd);
      $display("test tone done");
      @(posedge mclk) glatch <= 1'b1;
      u_cpu.wr(SEL_FC_CMD, 4'hC);
      @(posedge mclk);
      chk_pin("gate_in", 1'b1, gate_in);
      expect_irq("fc_gated", 2, 40, 1'b0);
      @(posedge mclk) gate <= 1'b1;
      expect_irq("fc_pulse", 2, 40, 1'b1);
      u_cpu.wr(SEL_FC_CMD, 4'h0);
      @(posedge mclk);
      chk_pin("gate_io", 1'b0, gate_in);
      $display("test fast_pulse done");
      expect_irq("tbase_off", 3, 80, 1'b0);
      u_cpu.wr(SEL_TIME_BASE, 4'hC);
      expect_irq("tbase_fast", 3, 80, 1'b1);
      u_cpu.wr(SEL_TIME_BASE, 4'h8);
      expect_irq("tbase_reserved", 3, 80, 1'b0);
      @(posedge mclk) slow <= 1'b1;
      u_cpu.wr(SEL_TIME_BASE, 4'hC);
      expect_irq("tbase_slow_res", 3, 80, 1'b0);
      u_cpu.wr(SEL_TIME_BASE, 4'hD);
      expect_irq("tbase_slow_ok", 3, 1100, 1'b1);
      $display("test time_base done");
      u_cpu.preset(SEL_TA_LOW, 12'hFFF);
      u_cpu.wr(SEL_TMR_A_CMD, 4'h8);
      expect_irq("ta_slow_res", 0, 200, 1'b0);
      u_cpu.wr(SEL_TMR_A_CMD, 4'h9);
      expect_irq("ta_rate1", 0, 1100, 1'b1);
      u_cpu.wr(SEL_TMR_A_CMD, 4'h0);
      u_cpu.preset(SEL_TB_LOW, 12'hFFF);
      u_cpu.wr(SEL_TMR_B_CMD, 4'h9);
      expect_irq("tb_rate1", 1, 300, 1'b1);
      u_cpu.wr(SEL_TMR_B_CMD, 4'h0);
      $display("test slow_rates done");
      u_cpu.wr(SEL_FC_CMD, 4'h4);
      expect_irq("fc_slow", 2, 60, 1'b1);
      u_cpu.wr(SEL_FC_CMD, 4'h6);
      expect_irq("fc_slow_res", 2, 80, 1'b0);
      @(posedge mclk) slow <= 1'b0;
      expect_irq("fc_fast_clk", 2, 80, 1'b1);
      u_cpu.wr(SEL_FC_CMD, 4'h0);
      $display("test fast_clock done");
      finish_test();
   end
endmodule : tb

bind dual_timer_and_fast_counter dual_timer_checker u_chk (.mclk(mclk), .resetn(resetn),
   .port_wr(port_wr), .port_rd(port_rd), .port_sel(port_sel), .port_wdata(port_wdata),
   .port_rdata(port_rdata), .gate_latch_high(gate_latch_high),
   .gate_pin_is_input(gate_pin_is_input), .time_base_irq(time_base_irq),
   .first_timer_overflow_irq(first_timer_overflow_irq),
   .second_timer_overflow_irq(second_timer_overflow_irq),
   .fast_counter_overflow_irq(fast_counter_overflow_irq),
   .tone_out_shared_pin(tone_out_shared_pin), .tone_out_dedicated_pin(tone_out_dedicated_pin));
